// ### inc/iog_pkg.sv
/*
 * Constants for the I/O module glue logic: host window offsets,
 * board register fields, reset values and the oscillator divider.
 * Assumes one 125 MHz system clock and an 8-bit ISA-style host bus.
 */
// How it works
// - Address bits 9..4 match jumpers; 16-byte window
// - Open jumper reads one, fitted reads zero
// - Default base address decodes at 300 hex
// - Offsets 0-3 select first port chip
// - Offsets 4-7 select second port chip
// - Offsets 8-11 reach counter data and mode
// - Offsets 12 and 13 share clock select
// - Offsets 14 and 15 share interrupt config
// - Pending interrupt drives high, else floats
// - First interrupt: port C0 one or counter0
// - Second interrupt: port C0 two or counter1
// - Third interrupt: external pin or counter2
// - Disabled interrupt output never drives line
// - Counter0 clocks from header or oscillator
// - Counter1: header, oscillator or counter0 out
// - Counter2: header, oscillator or counter1 out
// - Counters advance on selected rising edges
// - Counters count only while gate high
// - Cascaded counters form 32 or 48 bits
// - Each interrupt routes to one level 2-7
// - All interrupts may share one level
// - Bits 5..3 pick source, 2..0 enable
package iog_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_MHZ = 125;
	localparam int OSC_MHZ = 4;
	localparam int HDR_MAX_MHZ = 10;
	localparam logic [6:0] OSC_STEP = 7'(OSC_MHZ);
	localparam logic [6:0] OSC_MOD = 7'(CLK_MHZ);

	// ************************************************************
	// Window offsets
	// ************************************************************
	localparam logic [1:0] GRP_PPI1 = 2'h0;
	localparam logic [1:0] GRP_PPI2 = 2'h1;
	localparam logic [3:0] OFF_CTR_DATA0 = 4'h8;
	localparam logic [3:0] OFF_CTR_MODE = 4'hB;
	localparam logic [3:0] OFF_CLK_CFG = 4'hC;
	localparam logic [3:0] OFF_IRQ_CFG = 4'hE;

	// ************************************************************
	// Fields, masks and reset values
	// ************************************************************
	localparam int CLK_C0_BIT = 0;
	localparam int CLK_C1_LSB = 1;
	localparam int CLK_C2_LSB = 3;
	localparam int IRQ_EN_LSB = 0;
	localparam int IRQ_SRC_LSB = 3;
	localparam logic [7:0] CLK_CFG_MASK = 8'h1F;
	localparam logic [7:0] IRQ_CFG_MASK = 8'h3F;
	localparam logic [7:0] CLK_CFG_RST = 8'h00;
	localparam logic [7:0] IRQ_CFG_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [5:0] BASE_DEFAULT = 6'h30;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NUM_CTR = 3;
	localparam int NUM_LEVELS = 6;

	// Counter clock source codes (1x means cascade)
	typedef enum logic [1:0] {
		IOG_SRC_HEADER = 2'b00,
		IOG_SRC_OSC = 2'b01,
		IOG_SRC_CASCADE = 2'b10
	} iog_src_e;

endpackage

// ### hw/iog_counter.sv
/*
 * One 16-bit counter channel: loads bytes from the host and
 * advances on a one-cycle tick while its gate is high.
 * Assumes tick, gate and load come from the clk domain.
 */
module iog_counter
	import iog_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic gate,
	input wire logic load,
	input wire logic load_msb,
	input wire logic [7:0] load_data,
	output logic [15:0] count,
	output logic out
);

	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic out_r;

	// ************************************************************
	// Count logic
	// ************************************************************
	// Host load wins over a tick in the same cycle
	assign count_nxt = load ? (load_msb ? {load_data, count_r[7:0]}
		: {count_r[15:8], load_data})
		: (tick && gate) ? count_r + 16'h0001 : count_r;

	// Count register and cascade output (top bit)
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_r <= COUNT_RST;
			out_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			out_r <= count_r[15];
		end
	end

	assign count = count_r;
	assign out = out_r;

endmodule

// ### hw/iog_top.sv
/*
 * Glue logic of the I/O module: host window decode, board
 * registers, counter clock selection, three counters and the
 * interrupt routing to host levels 2..7.
 * Assumes host bus and header pins are asynchronous to clk and
 * that bus cycles last several clk periods.
 */
module iog_top
	import iog_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [9:0] isa_addr,
	input wire logic isa_aen,
	input wire logic isa_ior_n,
	input wire logic isa_iow_n,
	input wire logic [7:0] isa_data_in,
	output logic [7:0] isa_data_out,
	output logic isa_data_oe,
	input wire logic [5:0] base_address_jumpers,
	input wire logic [5:0] first_irq_level_jumpers,
	input wire logic [5:0] second_irq_level_jumpers,
	input wire logic [5:0] third_irq_level_jumpers,
	input wire logic counter0_header_clock,
	input wire logic counter1_header_clock,
	input wire logic counter2_header_clock,
	input wire logic [2:0] counter_gate,
	output logic [2:0] counter_out,
	input wire logic ppi1_port_c_bit_zero,
	input wire logic ppi2_port_c_bit_zero,
	input wire logic external_irq_pin,
	output logic ppi1_select,
	output logic ppi2_select,
	output logic [1:0] ppi_reg_index,
	output logic [5:0] irq_level_out,
	output logic [5:0] irq_level_oe
);

	// ************************************************************
	// Input synchroniser
	// ************************************************************
	localparam int SW = 54;
	localparam logic [SW-1:0] SYNC_RST = {10'h000, 3'h7, 8'h00,
		BASE_DEFAULT, 18'h00000, 9'h000};

	logic [SW-1:0] async_in;
	logic [SW-1:0] sync1_r;
	logic [SW-1:0] sync2_r;

	assign async_in = {isa_addr, isa_aen, isa_ior_n, isa_iow_n,
		isa_data_in, base_address_jumpers, third_irq_level_jumpers,
		second_irq_level_jumpers, first_irq_level_jumpers,
		counter2_header_clock, counter1_header_clock,
		counter0_header_clock, counter_gate, external_irq_pin,
		ppi2_port_c_bit_zero, ppi1_port_c_bit_zero};

	// Two flops; base jumpers come up at the default window
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync1_r <= SYNC_RST;
			sync2_r <= SYNC_RST;
		end else begin
			sync1_r <= async_in;
			sync2_r <= sync1_r;
		end
	end

	logic [9:0] addr_s;
	logic aen_s;
	logic ior_n_s;
	logic iow_n_s;
	logic [7:0] wdata_s;
	logic [5:0] base_s;
	logic [17:0] lvl_s;
	logic [2:0] hclk_s;
	logic [2:0] gate_s;
	logic [2:0] pin_src_s;

	assign {addr_s, aen_s, ior_n_s, iow_n_s, wdata_s, base_s, lvl_s,
		hclk_s, gate_s, pin_src_s} = sync2_r;

	// ************************************************************
	// Window decode
	// ************************************************************
	logic hit;
	logic [3:0] off;
	logic strobe;

	// Open jumper reads one, so the pins are the address bits
	assign hit = !aen_s && (addr_s[9:4] == base_s);
	assign off = addr_s[3:0];
	assign strobe = !ior_n_s || !iow_n_s;

	// Strobe edges and held cycle address and data
	logic iow_prev_r;
	logic ior_prev_r;
	logic acc_hit_r;
	logic [3:0] acc_off_r;
	logic [7:0] acc_data_r;
	logic wr_ok;
	logic rd_ok;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			iow_prev_r <= 1'b1;
			ior_prev_r <= 1'b1;
		end else begin
			iow_prev_r <= iow_n_s;
			ior_prev_r <= ior_n_s;
		end
	end

	// Capture address and data while a strobe is low, keep them after
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			acc_hit_r <= 1'b0;
			acc_off_r <= 4'h0;
			acc_data_r <= 8'h00;
		end else if (strobe) begin
			acc_hit_r <= hit;
			acc_off_r <= off;
			acc_data_r <= wdata_s;
		end
	end

	// Accesses take effect at the trailing edge of the strobe
	assign wr_ok = iow_n_s && !iow_prev_r && acc_hit_r;
	assign rd_ok = ior_n_s && !ior_prev_r && acc_hit_r;

	// ************************************************************
	// Port chip selects
	// ************************************************************
	logic ppi1_sel_nxt;
	logic ppi2_sel_nxt;
	logic ppi1_select_r;
	logic ppi2_select_r;
	logic [1:0] ppi_index_r;

	assign ppi1_sel_nxt = hit && strobe && (off[3:2] == GRP_PPI1);
	assign ppi2_sel_nxt = hit && strobe && (off[3:2] == GRP_PPI2);

	// Port A, B, C, config follow the low offset bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ppi1_select_r <= 1'b0;
			ppi2_select_r <= 1'b0;
			ppi_index_r <= 2'h0;
		end else begin
			ppi1_select_r <= ppi1_sel_nxt;
			ppi2_select_r <= ppi2_sel_nxt;
			ppi_index_r <= off[1:0];
		end
	end

	// ************************************************************
	// Board and counter mode registers
	// ************************************************************
	logic [7:0] clk_cfg_r;
	logic [7:0] irq_cfg_r;
	logic [7:0] mode_r;
	logic wr_clk_cfg;
	logic wr_irq_cfg;
	logic wr_mode;

	// Lowest offset bit ignored on the board registers
	assign wr_clk_cfg = wr_ok && (acc_off_r[3:1] == OFF_CLK_CFG[3:1]);
	assign wr_irq_cfg = wr_ok && (acc_off_r[3:1] == OFF_IRQ_CFG[3:1]);
	assign wr_mode = wr_ok && (acc_off_r == OFF_CTR_MODE);

	// Unused bits are masked off so they read zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			clk_cfg_r <= CLK_CFG_RST;
			irq_cfg_r <= IRQ_CFG_RST;
			mode_r <= MODE_RST;
		end else begin
			if (wr_clk_cfg)
				clk_cfg_r <= acc_data_r & CLK_CFG_MASK;
			if (wr_irq_cfg)
				irq_cfg_r <= acc_data_r & IRQ_CFG_MASK;
			if (wr_mode)
				mode_r <= acc_data_r;
		end
	end

	// ************************************************************
	// Oscillator tick: 4 MHz on average from 125 MHz
	// ************************************************************
	logic [6:0] osc_acc_r;
	logic [7:0] osc_sum;
	logic osc_wrap;
	logic osc_tick_r;

	assign osc_sum = {1'b0, osc_acc_r} + {1'b0, OSC_STEP};
	assign osc_wrap = osc_sum >= {1'b0, OSC_MOD};

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_acc_r <= 7'h00;
			osc_tick_r <= 1'b0;
		end else begin
			osc_acc_r <= osc_wrap ? 7'(osc_sum - {1'b0, OSC_MOD})
				: osc_sum[6:0];
			osc_tick_r <= osc_wrap;
		end
	end

	// ************************************************************
	// Counter clock selection and channels
	// ************************************************************
	logic [2:0] hclk_prev_r;
	logic [2:0] out_prev_r;
	logic [2:0] hclk_rise;
	logic [2:0] out_rise;
	logic [2:0] casc_rise;
	logic [2:0] ctr_out;
	logic [2:0] ctr_tick;
	logic [2:0] ctr_load;
	logic [2:0] wr_msb_r;
	logic [2:0] rd_msb_r;
	logic [1:0] csel [NUM_CTR];
	logic [15:0] ctr_count [NUM_CTR];

	// Header edges need 10 MHz or less to be seen
	assign hclk_rise = hclk_s & ~hclk_prev_r;
	assign out_rise = ctr_out & ~out_prev_r;
	assign casc_rise = {out_rise[1:0], 1'b0};
	assign csel[0] = {1'b0, clk_cfg_r[CLK_C0_BIT]};
	assign csel[1] = clk_cfg_r[CLK_C1_LSB +: 2];
	assign csel[2] = clk_cfg_r[CLK_C2_LSB +: 2];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hclk_prev_r <= 3'h0;
			out_prev_r <= 3'h0;
		end else begin
			hclk_prev_r <= hclk_s;
			out_prev_r <= ctr_out;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_CTR; i++) begin : g_ctr
			logic wr_data;
			logic rd_data;

			assign wr_data = wr_ok && (acc_off_r == OFF_CTR_DATA0 + 4'(i));
			assign rd_data = rd_ok && (acc_off_r == OFF_CTR_DATA0 + 4'(i));
			assign ctr_load[i] = wr_data;
			// Source code 1x takes the previous counter output
			assign ctr_tick[i] = csel[i][1] ? casc_rise[i]
				: csel[i][0] ? osc_tick_r : hclk_rise[i];

			// Byte pointers: low byte first; mode write restarts
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					wr_msb_r[i] <= 1'b0;
					rd_msb_r[i] <= 1'b0;
				end else begin
					wr_msb_r[i] <= !wr_mode && (wr_msb_r[i] ^ wr_data);
					rd_msb_r[i] <= !wr_mode && (rd_msb_r[i] ^ rd_data);
				end
			end

			iog_counter u_ctr (
				.clk(clk),
				.reset(reset),
				.tick(ctr_tick[i]),
				.gate(gate_s[i]),
				.load(wr_data),
				.load_msb(wr_msb_r[i]),
				.load_data(acc_data_r),
				.count(ctr_count[i]),
				.out(ctr_out[i])
			);
		end
	endgenerate

	// ************************************************************
	// Host read data
	// ************************************************************
	logic [1:0] ridx;
	logic [15:0] rcount;
	logic [7:0] rd_byte;
	logic rd_own;
	logic [7:0] data_out_r;
	logic data_oe_r;

	assign ridx = (off[1:0] == 2'h3) ? 2'h0 : off[1:0];
	assign rcount = ctr_count[ridx];
	assign rd_byte = (off[3:2] == OFF_CLK_CFG[3:2]) ?
		(off[1] ? irq_cfg_r : clk_cfg_r)
		: (off == OFF_CTR_MODE) ? mode_r
		: rd_msb_r[ridx] ? rcount[15:8] : rcount[7:0];
	// Offsets 0..7 are answered by the port chips themselves
	assign rd_own = hit && !ior_n_s && off[3];

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			data_out_r <= 8'h00;
			data_oe_r <= 1'b0;
		end else begin
			data_out_r <= rd_own ? rd_byte : 8'h00;
			data_oe_r <= rd_own;
		end
	end

	// ************************************************************
	// Interrupt sources, enables and level routing
	// ************************************************************
	logic [2:0] irq_src;
	logic [2:0] irq_drive_r;
	logic [5:0] lvl_drive;
	logic [5:0] lvl_out_r;
	logic [5:0] lvl_oe_r;

	// Source bit zero: port C0 or external pin; one: counter
	assign irq_src = (irq_cfg_r[IRQ_SRC_LSB +: 3] & ctr_out) |
		(~irq_cfg_r[IRQ_SRC_LSB +: 3] & pin_src_s);

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			irq_drive_r <= 3'h0;
		else
			irq_drive_r <= irq_src & irq_cfg_r[IRQ_EN_LSB +: 3];
	end

	// Any level jumper reading one passes its interrupt; shared OR
	genvar j;
	generate
		for (j = 0; j < NUM_LEVELS; j++) begin : g_lvl
			assign lvl_drive[j] = |(irq_drive_r &
				{lvl_s[12 + j], lvl_s[6 + j], lvl_s[j]});
		end
	endgenerate

	// Driven high while pending, released otherwise
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lvl_out_r <= 6'h00;
			lvl_oe_r <= 6'h00;
		end else begin
			lvl_out_r <= lvl_drive;
			lvl_oe_r <= lvl_drive;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign isa_data_out = data_out_r;
	assign isa_data_oe = data_oe_r;
	assign ppi1_select = ppi1_select_r;
	assign ppi2_select = ppi2_select_r;
	assign ppi_reg_index = ppi_index_r;
	assign counter_out = ctr_out;
	assign irq_level_out = lvl_out_r;
	assign irq_level_oe = lvl_oe_r;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_window_miss_quiet:
	assert property (!hit |=> !isa_data_oe)
		else $error("data driven outside the window");

	a_ppi1_select:
	assert property ((hit && strobe && off[3:2] == 2'h0) |=> ppi1_select)
		else $error("first port chip not selected");

	a_clk_cfg_alias:
	assert property ((wr_ok && acc_off_r == 4'hD) |=>
		clk_cfg_r == ($past(acc_data_r) & 8'h1F))
		else $error("offset 13 did not write clock select");

	a_irq_cfg_alias:
	assert property ((wr_ok && acc_off_r == 4'hF) |=>
		irq_cfg_r == ($past(acc_data_r) & 8'h3F))
		else $error("offset 15 did not write interrupt config");

	a_irq_disabled_quiet:
	assert property (!irq_cfg_r[0] |=> !irq_drive_r[0])
		else $error("disabled interrupt drives its level");

	a_irq_first_port:
	assert property ((irq_cfg_r[0] && !irq_cfg_r[3] && pin_src_s[0])
		|=> irq_drive_r[0])
		else $error("first interrupt missed port C0");

	a_irq_third_ctr:
	assert property ((irq_cfg_r[2] && irq_cfg_r[5] && ctr_out[2])
		|=> irq_drive_r[2])
		else $error("third interrupt missed counter 2");

	a_count_advance:
	assert property ((ctr_tick[0] && gate_s[0] && !ctr_load[0]) |=>
		ctr_count[0] == $past(ctr_count[0]) + 16'h0001)
		else $error("counter 0 did not advance on tick");

	a_gate_hold:
	assert property ((!gate_s[1] && !ctr_load[1]) |=> $stable(ctr_count[1]))
		else $error("counter 1 moved with gate low");

	a_level_drive_high:
	assert property ((irq_drive_r[0] && lvl_s[0]) |=>
		(irq_level_oe[0] && irq_level_out[0]))
		else $error("pending level not driven high");

endmodule

// ### testbench/iog_host_model.sv
/*
 * Host processor model: 8-bit I/O read and write cycles.
 * Assumes the bench calls its tasks and shares its clock.
 */
module iog_host_model (
	input wire logic clk,
	output logic [9:0] isa_addr,
	output logic isa_aen,
	output logic isa_ior_n,
	output logic isa_iow_n,
	output logic [7:0] isa_data_in,
	input wire logic [7:0] isa_data_out,
	input wire logic isa_data_oe,
	input wire logic ppi1_select,
	input wire logic ppi2_select,
	input wire logic [1:0] ppi_reg_index
);
	timeunit 1ns;
	timeprecision 100ps;
	logic dma;

	// ****************************************
	// Bus cycles
	// ****************************************

	// Idle bus at time zero
	initial begin
		dma = 1'b0;
		isa_addr = 10'h000;
		isa_aen = 1'b1;
		isa_ior_n = 1'b1;
		isa_iow_n = 1'b1;
		isa_data_in = 8'h00;
	end

	// Hold, then release lines with changing values
	task automatic rel();
		repeat (3) @(posedge clk);
		isa_addr <= ~isa_addr;
		isa_data_in <= ~isa_data_in;
		isa_aen <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// Write strobe held four clocks
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		isa_addr <= a;
		isa_data_in <= d;
		isa_aen <= dma;
		isa_iow_n <= 1'b0;
		repeat (4) @(posedge clk);
		isa_iow_n <= 1'b1;
		rel();
	endtask

	// Read: wait a bounded time for the data enable
	task automatic rd(input logic [9:0] a, output logic hit,
		output logic [7:0] d, output logic [3:0] sel);
		int n;
		hit = 1'b0;
		d = 8'h00;
		@(posedge clk);
		isa_addr <= a;
		isa_aen <= dma;
		isa_ior_n <= 1'b0;
		for (n = 0; n < 6 && hit !== 1'b1; n++) begin
			@(posedge clk);
			hit = isa_data_oe;
			d = isa_data_out;
		end
		sel = {ppi1_select, ppi2_select, ppi_reg_index};
		isa_ior_n <= 1'b1;
		rel();
	endtask
endmodule

// ### testbench/tb.sv
/*
 * Self-checking bench for the I/O glue logic.
 * Assumes iog_pkg and the host model are compiled first.
 */
module tb
	import iog_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset, isa_aen, isa_ior_n, isa_iow_n, isa_data_oe;
	logic [9:0] isa_addr;
	logic [7:0] isa_data_in, isa_data_out;
	logic [5:0] base_j, lvl1_j, lvl2_j, lvl3_j, irq_out, irq_oe;
	logic [5:0] irq_wire;
	logic [2:0] hdr, gate, cnt_out, src;
	logic ppi1_sel, ppi2_sel;
	logic [1:0] ppi_idx;
	logic [15:0] v;
	int fails, n_tests, i;
	logic [7:0] cfgs [6] = '{8'h07, 8'h04, 8'h00, 8'h3F, 8'h3F, 8'h07};
	logic [2:0] srcs [6] = '{3'h5, 3'h7, 3'h7, 3'h7, 3'h0, 3'h6};
	logic [5:0] exps [6] = '{6'h21, 6'h20, 6'h00, 6'h29, 6'h29, 6'h28};

	// Pull-down on every level line
	assign irq_wire = irq_oe & irq_out;

	iog_host_model host (
		.clk(clk),
		.isa_addr(isa_addr),
		.isa_aen(isa_aen),
		.isa_ior_n(isa_ior_n),
		.isa_iow_n(isa_iow_n),
		.isa_data_in(isa_data_in),
		.isa_data_out(isa_data_out),
		.isa_data_oe(isa_data_oe),
		.ppi1_select(ppi1_sel),
		.ppi2_select(ppi2_sel),
		.ppi_reg_index(ppi_idx)
	);

	iog_top DUT (
		.clk(clk),
		.reset(reset),
		.isa_addr(isa_addr),
		.isa_aen(isa_aen),
		.isa_ior_n(isa_ior_n),
		.isa_iow_n(isa_iow_n),
		.isa_data_in(isa_data_in),
		.isa_data_out(isa_data_out),
		.isa_data_oe(isa_data_oe),
		.base_address_jumpers(base_j),
		.first_irq_level_jumpers(lvl1_j),
		.second_irq_level_jumpers(lvl2_j),
		.third_irq_level_jumpers(lvl3_j),
		.counter0_header_clock(hdr[0]),
		.counter1_header_clock(hdr[1]),
		.counter2_header_clock(hdr[2]),
		.counter_gate(gate),
		.counter_out(cnt_out),
		.ppi1_port_c_bit_zero(src[0]),
		.ppi2_port_c_bit_zero(src[1]),
		.external_irq_pin(src[2]),
		.ppi1_select(ppi1_sel),
		.ppi2_select(ppi2_sel),
		.ppi_reg_index(ppi_idx),
		.irq_level_out(irq_out),
		.irq_level_oe(irq_oe)
	);

	// ****************************************
	// Tasks
	// ****************************************

	// 8 ns clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [9:0] a, input logic h_e,
		input logic [7:0] d_e);
		logic h;
		logic [7:0] d;
		logic [3:0] s;
		host.rd(a, h, d, s);
		chk({7'h00, h, d}, {7'h00, h_e, d_e});
	endtask

	// Rising header edges 112 ns apart, below the toggle limit
	task automatic tick(input int n);
		repeat (n) begin
			hdr <= 3'b111;
			repeat (7) @(posedge clk);
			hdr <= 3'b000;
			repeat (7) @(posedge clk);
		end
	endtask

	task automatic load(input logic [9:0] a, input logic [15:0] d);
		host.wr(10'h30B, 8'h00);
		host.wr(a, d[7:0]);
		host.wr(a, d[15:8]);
	endtask

	task automatic rcnt(input logic [9:0] a, output logic [15:0] d);
		logic h;
		logic [3:0] s;
		host.wr(10'h30B, 8'h00);
		host.rd(a, h, d[7:0], s);
		host.rd(a, h, d[15:8], s);
	endtask

	task automatic settle();
		repeat (8) @(posedge clk);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		reset = 1'b1;
		base_j = 6'h30;
		lvl1_j = 6'h01;
		lvl2_j = 6'h08;
		lvl3_j = 6'h20;
		hdr = 3'b000;
		gate = 3'b000;
		src = 3'b000;
		fails = 0;
		n_tests = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		rchk(10'h30C, 1'b1, CLK_CFG_RST);
		rchk(10'h30F, 1'b1, IRQ_CFG_RST);
		chk({irq_oe, irq_wire}, 16'h0000);
		host.wr(10'h30D, 8'hFF);
		rchk(10'h30C, 1'b1, CLK_CFG_MASK);
		host.wr(10'h30F, 8'hFF);
		rchk(10'h30E, 1'b1, IRQ_CFG_MASK);
		host.wr(10'h30E, 8'h00);
		host.wr(10'h30C, 8'h00);
		host.dma = 1'b1;
		rchk(10'h30C, 1'b0, 8'h00);
		host.dma = 1'b0;
		base_j <= 6'h22;
		rchk(10'h30C, 1'b0, 8'h00);
		rchk(10'h22C, 1'b1, 8'h00);
		base_j <= 6'h30;
		for (i = 0; i < 8; i++) begin
			host.rd(10'(10'h300 + i), v[8], v[7:0], v[12:9]);
			chk({3'h0, v[12:0]}, 16'({i < 4, i > 3, i[1:0], 9'h000}));
		end
		// Count, hold with gate low, wrap
		gate <= 3'b001;
		load(10'h308, 16'hFFF0);
		tick(5);
		gate <= 3'b000;
		tick(3);
		rcnt(10'h308, v);
		chk(v, 16'hFFF5);
		rcnt(10'h309, v);
		chk(v, 16'h0000);
		chk(16'(cnt_out), 16'h0001);
		gate <= 3'b001;
		tick(11);
		chk(16'(cnt_out), 16'h0000);
		// Three counters chained to 48 bits
		host.wr(10'h30C, 8'h14);
		gate <= 3'b111;
		load(10'h309, 16'h7FFF);
		load(10'h30A, 16'h7FFF);
		load(10'h308, 16'h7FFF);
		tick(1);
		rcnt(10'h309, v);
		chk(v, 16'h8000);
		rcnt(10'h30A, v);
		chk(v, 16'h8000);
		// Interrupt sources and enables
		for (i = 0; i < 6; i++) begin
			src <= srcs[i];
			host.wr(10'h30E, cfgs[i]);
			settle();
			chk({irq_oe, irq_wire}, {2{exps[i]}});
		end
		// Every level, all three outputs shared
		src <= 3'b111;
		host.wr(10'h30E, 8'h07);
		for (i = 0; i < 6; i++) begin
			lvl1_j <= 6'h01 << i;
			lvl2_j <= 6'h01 << i;
			lvl3_j <= 6'h01 << i;
			settle();
			chk({irq_oe, irq_wire}, {2{6'h01 << i}});
		end
		// Oscillator: 250 clocks give exactly 8 ticks
		gate <= 3'b000;
		host.wr(10'h30C, 8'h01);
		load(10'h308, 16'h0000);
		gate <= 3'b001;
		repeat (250) @(posedge clk);
		gate <= 3'b000;
		rcnt(10'h308, v);
		chk(v, 16'h0008);
		test_done();
	end
endmodule
